// [rtl/phy_upper_regs_cfg.svh]
/*
 register addresses, field positions and reset values of the upper register
 bank. assumes inclusion by bare name from the package and the design.
*/
`ifndef PHY_UPPER_REGS_CFG_SVH
`define PHY_UPPER_REGS_CFG_SVH
`define ADDR_LINE_VIEW 8'h15
`define ADDR_TEST_WR 8'h16
`define ADDR_TEST_SET 8'h17
`define ADDR_TEST_CLR 8'h18
`define ADDR_GAP_LO 8'h19
`define ADDR_GAP_HI 8'h2E
`define ADDR_ESCAPE 8'h2F
`define ADDR_VENDOR_LO 8'h30
`define ADDR_BSE_WR 8'h3D
`define ADDR_BSE_SET 8'h3E
`define ADDR_BSE_CLR 8'h3F
`define ADDR_IMM_MASK 8'h3F
`define ADDR_EXT_LIMIT 8'h40
`define BIT_BV_RISE 2
`define BIT_BV_FALL 3
`define TEST_RESET 8'h00
`define BSE_RESET 8'h00
`define BYTE_ZERO 8'h00
`endif

// [rtl/phy_upper_regs_pkg.sv]
/*
 types of the upper register bank. assumes the cfg header beside it.
*/
`include "phy_upper_regs_cfg.svh"
package phy_upper_regs_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {OP_WRITE, OP_SET, OP_CLR} reg_op_t;
endpackage : phy_upper_regs_pkg

// [rtl/phy_upper_regs.sv]
/*
 upper register bank of a usb transceiver: line view, test byte, b-session
 event control and alternate event reporting. assumes the transfer engine
 gives a decoded address (immediate, or extended after the escape) with
 one-cycle read and write strobes, and takes a one-cycle report pulse.
*/
`timescale 1ns/1ps
`include "phy_upper_regs_cfg.svh"

// Operation
// - line view returns live line level
// - test byte read, load, set, clear
// - test byte resets zero, affects nothing
// - gap addresses accepted, no state change
// - escape address holds no data
// - immediate registers sit at extended bottom
// - vendor range 30h to 3Ch reserved
// - event control read, load, set, clear
// - fall enable reports falling session edge
// - rise enable reports rising session edge
// - extended 00h-3Fh alias immediate registers
module phy_upper_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access from transfer engine
  input wire logic [7:0] reg_addr,
  input wire logic reg_ext,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire phy_upper_regs_pkg::reg_byte_t reg_wdata,
  output phy_upper_regs_pkg::reg_byte_t reg_rdata,
  output logic reg_rvalid,
  // line and session levels
  input wire logic bus_line_level_hi,
  input wire logic bus_line_level_lo,
  input wire logic b_session_valid,
  // alternate event report request
  output logic alternate_event_flag
);
  import phy_upper_regs_pkg::*;

  // ***********************************
  // address decode
  // ***********************************
  reg_byte_t test_q;
  reg_byte_t bse_q;
  reg_byte_t rdata_d;
  reg_byte_t eff_addr;
  logic addr_ok;
  logic bv_q;

  always_comb begin
    eff_addr = reg_addr & `ADDR_IMM_MASK;
    addr_ok = !reg_ext || (reg_addr < `ADDR_EXT_LIMIT);
  end

  // ***********************************
  // test byte
  // ***********************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_q <= `TEST_RESET;
    end else if (reg_wr && addr_ok) begin
      case (eff_addr)
        `ADDR_TEST_WR: test_q <= reg_wdata;
        `ADDR_TEST_SET: test_q <= test_q | reg_wdata;
        `ADDR_TEST_CLR: test_q <= test_q & ~reg_wdata;
        default: test_q <= test_q;
      endcase
    end
  end

  // ***********************************
  // b-session event control
  // ***********************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bse_q <= `BSE_RESET;
    end else if (reg_wr && addr_ok) begin
      case (eff_addr)
        `ADDR_BSE_WR: bse_q <= reg_wdata;
        `ADDR_BSE_SET: bse_q <= bse_q | reg_wdata;
        `ADDR_BSE_CLR: bse_q <= bse_q & ~reg_wdata;
        default: bse_q <= bse_q;
      endcase
    end
  end

  // ***********************************
  // read path
  // ***********************************
  always_comb begin
    case (eff_addr)
      `ADDR_LINE_VIEW:
        rdata_d = {6'h00, bus_line_level_hi, bus_line_level_lo};
      `ADDR_TEST_WR, `ADDR_TEST_SET, `ADDR_TEST_CLR: rdata_d = test_q;
      `ADDR_BSE_WR, `ADDR_BSE_SET, `ADDR_BSE_CLR: rdata_d = bse_q;
      default: rdata_d = `BYTE_ZERO;
    endcase
    if (!addr_ok) begin
      rdata_d = `BYTE_ZERO;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `BYTE_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ***********************************
  // session edge reports
  // ***********************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bv_q <= 1'b0;
      alternate_event_flag <= 1'b0;
    end else begin
      bv_q <= b_session_valid;
      alternate_event_flag <=
        (bv_q && !b_session_valid && bse_q[`BIT_BV_FALL]) ||
        (!bv_q && b_session_valid && bse_q[`BIT_BV_RISE]);
    end
  end
endmodule : phy_upper_regs

// [test/phy_upper_regs_checker.sv]
/* checker of the upper bank; sees only the bank's ports */
`timescale 1ns/1ps
module phy_upper_regs_checker (
  input wire logic sys_clk, rst_n, reg_ext, reg_wr, reg_rd, reg_rvalid,
  input wire logic bus_line_level_hi, bus_line_level_lo, b_session_valid,
  input wire logic alternate_event_flag,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire rd16 = reg_rd && !reg_wr && reg_addr == 8'h16;
  rvalid_pulse_a: assert property (reg_rd |=> reg_rvalid)
    else $error("no read answer");
  line_view_a: assert property (reg_rd && reg_addr == 8'h15 |=>
    reg_rdata == {6'h00, $past(bus_line_level_hi), $past(bus_line_level_lo)})
    else $error("line view wrong");
  gap_zero_a: assert property (reg_rd && reg_addr inside {[8'h19:8'h3C]}
    |=> reg_rdata == 8'h00) else $error("gap read not zero");
  test_load_a: assert property (reg_wr && reg_addr == 8'h16 ##2 rd16
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("load lost");
  test_set_a: assert property (reg_wr && reg_addr == 8'h17 ##2 rd16
    |=> (reg_rdata & $past(reg_wdata, 3)) == $past(reg_wdata, 3))
    else $error("set lost");
  test_clr_a: assert property (reg_wr && reg_addr == 8'h18 ##2 rd16
    |=> (reg_rdata & $past(reg_wdata, 3)) == 8'h00) else $error("clear lost");
  ctrl_load_a: assert property (reg_wr && reg_addr == 8'h3D ##2 reg_rd
    && reg_addr == 8'h3D |=> reg_rdata == $past(reg_wdata, 3))
    else $error("control load lost");
  edge_only_a: assert property (alternate_event_flag |->
    $past(b_session_valid) != $past(b_session_valid, 2)) else $error("stray");
endmodule : phy_upper_regs_checker
bind phy_upper_regs phy_upper_regs_checker phy_upper_regs_checker_inst (.*);

// [test/link_model.sv]
/* link side: strobed register access; assumes calls from a falling edge */
`timescale 1ns/1ps
module link_model (
  input wire logic sys_clk,
  input wire logic [7:0] reg_rdata,
  output logic reg_ext, reg_wr, reg_rd,
  output logic [7:0] reg_addr, reg_wdata
);
  initial {reg_ext, reg_wr, reg_rd, reg_addr, reg_wdata} = 19'h00000;
  task acc(input logic w, x, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge sys_clk);
    {reg_wr, reg_rd, reg_ext, reg_addr, reg_wdata} = {w, !w, x, a, d};
    @(negedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
    q = reg_rdata;
  endtask : acc
endmodule : link_model

// [test/phy_upper_regs_tb.sv]
/* bench of the upper bank; link model makes accesses, bench drives levels */
`timescale 1ns/1ps
module phy_upper_regs_tb;
  logic sys_clk, rst_n, hi, lo, bv, reg_ext, reg_wr, reg_rd, reg_rvalid, flag;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  int fail_count = 0, total_checks = 0;
  phy_upper_regs phy_upper_regs_inst (.sys_clk, .rst_n, .reg_addr, .reg_ext,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
    .bus_line_level_hi(hi), .bus_line_level_lo(lo), .b_session_valid(bv),
    .alternate_event_flag(flag));
  link_model link_model_inst (.sys_clk, .reg_rdata, .reg_ext, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata);
  initial begin sys_clk = 0; forever #25 sys_clk = ~sys_clk; end
  task chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin fail_count++; $display("BAD %0t %h %h", $time, g, e); end
  endtask : chk
  task wr(input logic [7:0] a, d, input logic x = 0);
    link_model_inst.acc(1, x, a, d, q);
  endtask : wr
  task rd(input logic [7:0] a, e, input logic x = 0);
    link_model_inst.acc(0, x, a, 8'h00, q);
    chk(q, e);
  endtask : rd
  task ev(input logic v, e);
    @(negedge sys_clk) bv = v;
    @(negedge sys_clk) chk({7'h00, flag}, {7'h00, e});
    @(negedge sys_clk) chk({7'h00, flag}, 8'h00);
  endtask : ev
  task wrap_up;
    $display("checks %0d bad %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin #100000; fail_count++; wrap_up; end
  initial begin
    {rst_n, hi, lo, bv} = 4'h0;
    repeat (6) @(negedge sys_clk);
    rst_n = 1;
    rd(8'h15, 8'h00); rd(8'h16, 8'h00); rd(8'h3D, 8'h00);
    hi = 1; rd(8'h15, 8'h02); hi = 0; lo = 1; rd(8'h15, 8'h01);
    $display("reset and line view done");
    wr(8'h16, 8'hA5); rd(8'h16, 8'hA5); wr(8'h17, 8'h0A); rd(8'h16, 8'hAF);
    wr(8'h18, 8'h05, 1); rd(8'h16, 8'hAA, 1);
    for (int i = 8'h19; i < 8'h3D; i++) begin wr(8'(i), 8'hFF); rd(8'(i), 8'h00); end
    rd(8'h16, 8'hAA); rd(8'h3D, 8'h00);
    $display("test byte and gaps done");
    wr(8'h3D, 8'h04); rd(8'h3D, 8'h04);
    ev(1, 1); ev(0, 0);
    wr(8'h3E, 8'h08); wr(8'h3F, 8'h04); rd(8'h3D, 8'h08);
    ev(1, 0); ev(0, 1);
    $display("session events done");
    wrap_up;
  end
endmodule : phy_upper_regs_tb
